//--- hdl/sgs_regs.svh
`ifndef SGS_REGS_SVH
`define SGS_REGS_SVH

// ********************************************
// Register offsets (byte addresses)
// ********************************************
`define SGS_CFG_OFS 8'h00
`define SGS_OVR_OFS 8'h04
`define SGS_REM_OFS 8'h08
`define SGS_EVM_OFS 8'h0C
`define SGS_STA_OFS 8'h10
`define SGS_TS_OFS 8'h14

// ********************************************
// Field positions
// ********************************************
`define SGS_CFG_CNT_LSB 0
`define SGS_OVR_EN_BIT 0
`define SGS_OVR_TGT_LSB 4
`define SGS_REM_TGT_LSB 0
`define SGS_EVM_ON_BIT 0
`define SGS_EVM_OFF_BIT 1
`define SGS_STA_GRP_LSB 0
`define SGS_STA_FAIL_BIT 4
`define SGS_STA_OVR_BIT 5
`define SGS_STA_LVL_LSB 8

// ********************************************
// Reset values and codes
// ********************************************
`define SGS_CFG_RST 3'h0
`define SGS_GRP_RST 3'h0
`define SGS_TGT_NONE 4'h0
`define SGS_EVM_RST 2'h3
`define SGS_RESP_OKAY 2'h0
`define SGS_RESP_SLVERR 2'h2

`endif

//--- hdl/sgs_pkg.sv
package sgs_pkg;

    // Kind of selector event
    typedef enum logic [1:0] {
        EVT_ACTIVE = 2'b00,
        EVT_OVERRIDE = 2'b01,
        EVT_FAIL = 2'b10,
        EVT_REMOTE = 2'b11
    } evt_code_t;

    // One event with its timestamp
    typedef struct packed {
        evt_code_t code;
        logic on;
        logic [3:0] group;
        logic [31:0] stamp;
    } evt_t;

endpackage

//--- hdl/req_conditioner.sv
`timescale 1ns/1ps

// ********************************************
// Request pin synchroniser with edge detect
// ********************************************
module req_conditioner (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic pin_in,
    output logic level,
    output logic rise
);

    logic sync1_r, sync2_r, prev_r;
    logic sync1_nxt, sync2_nxt, prev_nxt;

    // Two stages, then one more for the edge
    always_comb begin
        sync1_nxt = pin_in;
        sync2_nxt = sync1_r;
        prev_nxt = sync2_r;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r <= prev_nxt;
        end
    end

    // Held level and one-cycle rising pulse
    assign level = sync2_r;
    assign rise = sync2_r & ~prev_r;

endmodule // req_conditioner

//--- hdl/setting_group_selector.sv
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "sgs_regs.svh"

// Contract
// - Up to eight groups; exactly one group is active at any time.
// - After reset group one is active; idle while one group used.
// - With several groups used, request inputs decide activation.
// - One independent request input per group.
// - Each request may be a single pulse or a held level.
// - Fixed priority, group one highest; highest requested group wins.
// - A pulse-activated group stays active until another is requested.
// - A held level blocks lower-priority pin and remote requests; override targets are not blocked.
// - A held level on group eight blocks nothing.
// - Override suspends automatic arbitration; operator commands only.
// - Override target acts only when override set and group used.
// - Override target None or 1..8, pulse mode; last group stays.
// - Held levels resume control right after override is cleared.
// - Override resets off, gates remote/local changes, stays until cleared.
// - Current group reads one to eight, group one after reset.
// - Used group count one to eight, default one; new groups init.
// - Remote request None or 1..8; blocked by higher held requests.
// - One status change per cycle raises a timestamped event, group change first; on/off storage selectable.
// - Requests to unused groups fail; failure flag while it persists.
module setting_group_selector import sgs_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] group_req_in,
    output logic [3:0] current_group,
    output logic [7:0] group_init,
    output logic request_fail,
    output logic evt_valid,
    output evt_t evt
);

    // ********************************************
    // Request inputs
    // ********************************************
    logic [7:0] lvl, rise;

    // One conditioner per group input
    for (genvar g = 0; g < 8; g++) begin : g_req
        req_conditioner u_cond (
            .aclk(aclk),
            .aresetn(aresetn),
            .pin_in(group_req_in[g]),
            .level(lvl[g]),
            .rise(rise[g])
        );
    end

    // ********************************************
    // State
    // ********************************************
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic w_lane0_r, w_lane0_nxt;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic ovr_en_r, ovr_en_nxt;
    logic [3:0] ovr_tgt_r, ovr_tgt_nxt, rem_tgt_r, rem_tgt_nxt;
    logic ovr_cmd_r, ovr_cmd_nxt, rem_cmd_r, rem_cmd_nxt;
    logic [1:0] evm_r, evm_nxt;
    logic [2:0] grp_r, grp_nxt;
    logic resume_r, resume_nxt, rej_r, rej_nxt, fail_r, fail_nxt;
    logic [7:0] init_r, init_nxt;
    logic [31:0] ts_r, ts_nxt;
    logic evt_valid_r, evt_valid_nxt;
    evt_t evt_r, evt_nxt;

    logic wr_do;
    logic [7:0] en, blk, req;
    logic [2:0] win, ovr_idx, rem_idx;
    logic ovr_ok, rem_ok, ovr_bad, rem_bad;

    // ********************************************
    // AXI4-Lite slave
    // ********************************************
    assign s_axi_awready = ~aw_held_r & ~bvalid_r;
    assign s_axi_wready = ~w_held_r & ~bvalid_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign wr_do = aw_held_r & w_held_r & ~bvalid_r;

    // Address and data accepted in either order, response after both
    always_comb begin
        aw_addr_nxt = aw_addr_r;
        aw_held_nxt = aw_held_r;
        w_data_nxt = w_data_r;
        w_lane0_nxt = w_lane0_r;
        w_held_nxt = w_held_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_nxt = s_axi_awaddr;
            aw_held_nxt = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data_nxt = s_axi_wdata;
            w_lane0_nxt = s_axi_wstrb[0];
            w_held_nxt = 1'b1;
        end
        if (wr_do) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (aw_addr_r <= `SGS_TS_OFS && aw_addr_r[1:0] == 2'h0)
                ? `SGS_RESP_OKAY : `SGS_RESP_SLVERR;
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `SGS_RESP_OKAY;
            rdata_nxt = 32'h0000_0000;
            case (s_axi_araddr)
                `SGS_CFG_OFS: rdata_nxt[`SGS_CFG_CNT_LSB +: 3] = cnt_r;
                `SGS_OVR_OFS: begin
                    rdata_nxt[`SGS_OVR_EN_BIT] = ovr_en_r;
                    rdata_nxt[`SGS_OVR_TGT_LSB +: 4] = ovr_tgt_r;
                end
                `SGS_REM_OFS: rdata_nxt[`SGS_REM_TGT_LSB +: 4] = rem_tgt_r;
                `SGS_EVM_OFS: rdata_nxt[1:0] = evm_r;
                `SGS_STA_OFS: begin
                    // Group reads as one to eight
                    rdata_nxt[`SGS_STA_GRP_LSB +: 4] = {1'b0, grp_r} + 4'h1;
                    rdata_nxt[`SGS_STA_FAIL_BIT] = fail_r;
                    rdata_nxt[`SGS_STA_OVR_BIT] = ovr_en_r;
                    rdata_nxt[`SGS_STA_LVL_LSB +: 8] = lvl;
                end
                `SGS_TS_OFS: rdata_nxt = ts_r;
                default: rresp_nxt = `SGS_RESP_SLVERR;
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    // Settings written by software
    always_comb begin
        cnt_nxt = cnt_r;
        ovr_en_nxt = ovr_en_r;
        ovr_tgt_nxt = ovr_tgt_r;
        rem_tgt_nxt = rem_tgt_r;
        evm_nxt = evm_r;
        ovr_cmd_nxt = 1'b0;
        rem_cmd_nxt = 1'b0;
        if (wr_do && w_lane0_r) begin
            case (aw_addr_r)
                `SGS_CFG_OFS: cnt_nxt = w_data_r[`SGS_CFG_CNT_LSB +: 3];
                `SGS_OVR_OFS: begin
                    // Stays set until software clears it
                    ovr_en_nxt = w_data_r[`SGS_OVR_EN_BIT];
                    ovr_tgt_nxt = w_data_r[`SGS_OVR_TGT_LSB +: 4];
                    // Nonzero target is a one-shot command
                    ovr_cmd_nxt = w_data_r[`SGS_OVR_TGT_LSB +: 4] != 4'h0;
                end
                `SGS_REM_OFS: begin
                    rem_tgt_nxt = w_data_r[`SGS_REM_TGT_LSB +: 4];
                    rem_cmd_nxt = w_data_r[`SGS_REM_TGT_LSB +: 4] != 4'h0;
                end
                `SGS_EVM_OFS: evm_nxt = w_data_r[1:0];
                default: ;
            endcase
        end
    end

    // ********************************************
    // Arbitration
    // ********************************************
    always_comb begin
        // Group i is used while i does not exceed the count
        for (int i = 0; i < 8; i++) begin
            en[i] = 3'(i) <= cnt_r;
        end
        // Held level blocks lower groups; group eight blocks none
        blk[0] = 1'b0;
        for (int i = 1; i < 8; i++) begin
            blk[i] = blk[i - 1] | lvl[i - 1];
        end
        // Edge or, right after override release, the held level
        req = (rise | (lvl & {8{resume_r}})) & ~blk & en;
        win = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (req[i]) begin
                win = 3'(i);
            end
        end
        ovr_idx = 3'(ovr_tgt_r - 4'h1);
        rem_idx = 3'(rem_tgt_r - 4'h1);
        ovr_ok = ovr_cmd_r & ovr_en_r & ovr_tgt_r <= 4'h8
            & en[ovr_idx];
        ovr_bad = ovr_cmd_r & ~ovr_ok;
        rem_ok = rem_cmd_r & ovr_en_r & rem_tgt_r <= 4'h8
            & en[rem_idx] & ~blk[rem_idx];
        rem_bad = rem_cmd_r & ~rem_ok;
    end

    // Next active group, one change per cycle
    always_comb begin
        grp_nxt = grp_r;
        rej_nxt = rej_r;
        if (ovr_ok) begin
            grp_nxt = ovr_idx;
            rej_nxt = 1'b0;
        end else if (rem_ok) begin
            grp_nxt = rem_idx;
            rej_nxt = 1'b0;
        end else if (!en[grp_r]) begin
            grp_nxt = `SGS_GRP_RST;
        end else if (!ovr_en_r && cnt_r != 3'h0 && req != 8'h00) begin
            grp_nxt = win;
        end
        // A rejected command never masks a pin request or the clamp
        if (ovr_bad || rem_bad) begin
            rej_nxt = 1'b1;
        end
        // Otherwise the last group holds
        resume_nxt = ovr_en_r & ~ovr_en_nxt;
        fail_nxt = rej_nxt | (|(lvl & ~en));
        ts_nxt = ts_r + 32'h0000_0001;
        // Newly used groups load default contents
        init_nxt = 8'h00;
        for (int i = 0; i < 8; i++) begin
            init_nxt[i] = 3'(i) <= cnt_nxt && 3'(i) > cnt_r;
        end
    end

    // ********************************************
    // Events
    // ********************************************
    always_comb begin
        evt_nxt.code = EVT_ACTIVE;
        evt_nxt.on = 1'b1;
        evt_nxt.group = {1'b0, grp_nxt} + 4'h1;
        evt_nxt.stamp = ts_r;
        evt_valid_nxt = 1'b0;
        if (grp_nxt != grp_r) begin
            evt_valid_nxt = 1'b1;
        end else if (ovr_en_nxt != ovr_en_r) begin
            evt_nxt.code = EVT_OVERRIDE;
            evt_nxt.on = ovr_en_nxt;
            evt_valid_nxt = 1'b1;
        end else if (fail_nxt != fail_r) begin
            evt_nxt.code = EVT_FAIL;
            evt_nxt.on = fail_nxt;
            evt_valid_nxt = 1'b1;
        end else if (rem_cmd_r) begin
            evt_nxt.code = EVT_REMOTE;
            evt_nxt.group = rem_tgt_r;
            evt_valid_nxt = 1'b1;
        end
        // Stored only when its polarity is selected
        if (evt_nxt.on ? !evm_r[`SGS_EVM_ON_BIT]
                       : !evm_r[`SGS_EVM_OFF_BIT]) begin
            evt_valid_nxt = 1'b0;
        end
    end

    // Register all state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_addr_r <= 8'h00;
            aw_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_lane0_r <= 1'b0;
            w_held_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `SGS_RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= `SGS_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            cnt_r <= `SGS_CFG_RST;
            ovr_en_r <= 1'b0;
            ovr_tgt_r <= `SGS_TGT_NONE;
            rem_tgt_r <= `SGS_TGT_NONE;
            ovr_cmd_r <= 1'b0;
            rem_cmd_r <= 1'b0;
            evm_r <= `SGS_EVM_RST;
            grp_r <= `SGS_GRP_RST;
            resume_r <= 1'b0;
            rej_r <= 1'b0;
            fail_r <= 1'b0;
            init_r <= 8'h00;
            ts_r <= 32'h0000_0000;
            evt_valid_r <= 1'b0;
            evt_r <= '0;
        end else begin
            aw_addr_r <= aw_addr_nxt;
            aw_held_r <= aw_held_nxt;
            w_data_r <= w_data_nxt;
            w_lane0_r <= w_lane0_nxt;
            w_held_r <= w_held_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            cnt_r <= cnt_nxt;
            ovr_en_r <= ovr_en_nxt;
            ovr_tgt_r <= ovr_tgt_nxt;
            rem_tgt_r <= rem_tgt_nxt;
            ovr_cmd_r <= ovr_cmd_nxt;
            rem_cmd_r <= rem_cmd_nxt;
            evm_r <= evm_nxt;
            grp_r <= grp_nxt;
            resume_r <= resume_nxt;
            rej_r <= rej_nxt;
            fail_r <= fail_nxt;
            init_r <= init_nxt;
            ts_r <= ts_nxt;
            evt_valid_r <= evt_valid_nxt;
            evt_r <= evt_nxt;
        end
    end

    // Outputs, one group encoded
    assign current_group = {1'b0, grp_r} + 4'h1;
    assign group_init = init_r;
    assign request_fail = fail_r;
    assign evt_valid = evt_valid_r;
    assign evt = evt_r;

    // ********************************************
    // Checks
    // ********************************************
    chk_reset_group: assert property (@(posedge aclk)
        $rose(aresetn) |-> grp_r == 3'h0 && current_group == 4'h1)
        else $error("group not one after reset");
    chk_idle_single: assert property (@(posedge aclk)
        disable iff (!aresetn) cnt_r == 3'h0 |=> grp_r == 3'h0)
        else $error("group moved while one group used");
    chk_top_priority: assert property (@(posedge aclk)
        disable iff (!aresetn)
        rise[0] && !ovr_en_r && !ovr_cmd_r && cnt_r != 3'h0
        |=> grp_r == 3'h0)
        else $error("group one request lost");
    chk_pulse_hold: assert property (@(posedge aclk)
        disable iff (!aresetn)
        req == 8'h00 && !ovr_cmd_r && !rem_cmd_r && en[grp_r]
        |=> $stable(grp_r))
        else $error("group changed without request");
    chk_static_block: assert property (@(posedge aclk)
        disable iff (!aresetn)
        lvl[0] && !ovr_ok && grp_r == 3'h0 |=> grp_r == 3'h0)
        else $error("held group one was overtaken");
    chk_override_hold: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ovr_en_r && !ovr_cmd_r && !rem_cmd_r && en[grp_r]
        ##1 ovr_en_r && !ovr_cmd_r && !rem_cmd_r && en[grp_r]
        |=> grp_r == $past(grp_r, 2))
        else $error("inputs acted during override");
    chk_override_target: assert property (@(posedge aclk)
        disable iff (!aresetn)
        ovr_cmd_r && ovr_en_r && ovr_tgt_r <= 4'h8
        && 3'(ovr_tgt_r - 4'h1) <= cnt_r
        |=> current_group == $past(ovr_tgt_r))
        else $error("override target not applied");
    chk_resume_static: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $fell(ovr_en_r) && req != 8'h00 && cnt_r != 3'h0 && en[grp_r]
        |=> grp_r == $past(win))
        else $error("held request ignored after release");
    chk_fail_flag: assert property (@(posedge aclk)
        disable iff (!aresetn) |(lvl & ~en) |=> request_fail)
        else $error("failure flag missing");
    chk_event_mask: assert property (@(posedge aclk)
        disable iff (!aresetn)
        evt_valid |-> (evt.on ? $past(evm_r[0]) : $past(evm_r[1])))
        else $error("event stored against mask");

endmodule // setting_group_selector

//--- tb/pin_source.sv
`timescale 1ns/1ps

// ********************************************
// Request sources: user logic and field inputs
// ********************************************
module pin_source (
    input wire logic aclk,
    output logic [7:0] pins
);
    // All request lines idle at time zero
    initial begin
        pins = 8'h00;
    end

    // Raise request lines and keep them as static levels
    task automatic raise(input logic [7:0] m);
        @(posedge aclk);
        pins <= pins | m;
    endtask

    // Release request lines
    task automatic lower(input logic [7:0] m);
        @(posedge aclk);
        pins <= pins & ~m;
    endtask

    // Short pulse, long enough to pass the synchroniser
    task automatic pulse(input logic [7:0] m);
        raise(m);
        repeat (2) @(posedge aclk);
        lower(m);
    endtask
endmodule // pin_source

//--- tb/tb.sv
`timescale 1ns/1ps
`include "sgs_regs.svh"

module tb import sgs_pkg::*;;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, request_fail, evt_valid;
    logic [7:0] awaddr, araddr, pins, group_init, init_seen;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb, current_group;
    logic [1:0] bresp, rresp;
    evt_t evt, last_evt;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;

    setting_group_selector i_setting_group_selector (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(awaddr[4:2]),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(araddr[4:2]),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .group_req_in(pins), .current_group(current_group),
        .group_init(group_init), .request_fail(request_fail),
        .evt_valid(evt_valid), .evt(evt)
    );

    pin_source i_pin_source (.aclk(aclk), .pins(pins));

    // Clock generator
    always #4 aclk = ~aclk;

    // Hang guard and event/init capture
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        init_seen <= aresetn ? (init_seen | group_init) : 8'h00;
        if (evt_valid === 1'b1) last_evt <= evt;
        if (cycles == 20000) begin
            fail_count++;
            conclude();
        end
    end

    // ********************************************
    // Shared helpers
    // ********************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // AXI4-Lite write, response code compared
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic aw_t, w_t, b_t;
        logic [1:0] r;
        b_t = 1'b0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = awvalid && (awready === 1'b1);
            w_t = wvalid && (wready === 1'b1);
            b_t = (bvalid === 1'b1);
            r = bresp;
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
            if (b_t) bready <= 1'b0;
        end
        check(r, er);
    endtask

    // AXI4-Lite read, masked data and response compared
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                      input logic [1:0] er);
        logic ar_t, r_t;
        logic [31:0] d;
        logic [1:0] r;
        r_t = 1'b0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        while (!r_t) begin
            @(negedge aclk);
            ar_t = arvalid && (arready === 1'b1);
            r_t = (rvalid === 1'b1);
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_t) arvalid <= 1'b0;
            if (r_t) rready <= 1'b0;
        end
        check(r, er);
        if (er == `SGS_RESP_OKAY) check(d & m, e);
    endtask

    // Let requests settle, then compare the active group
    task automatic grp(input logic [3:0] e);
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        check(current_group, e);
    endtask

    task conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ********************************************
    // Scenarios
    // ********************************************
    task automatic t_reset;
        check(current_group, 4'h1);
        rd(`SGS_CFG_OFS, 32'h7, 32'h0, `SGS_RESP_OKAY);
        rd(`SGS_OVR_OFS, 32'hF1, 32'h0, `SGS_RESP_OKAY);
        rd(`SGS_REM_OFS, 32'hF, 32'h0, `SGS_RESP_OKAY);
        rd(`SGS_EVM_OFS, 32'h3, 32'h3, `SGS_RESP_OKAY);
        rd(`SGS_STA_OFS, 32'h3F, 32'h1, `SGS_RESP_OKAY);
        rd(8'h1C, 32'h0, 32'h0, `SGS_RESP_SLVERR);
    endtask

    // One group in use: requests change nothing, unused group fails
    task automatic t_idle;
        i_pin_source.raise(8'h04);
        grp(4'h1);
        check(request_fail, 1'b1);
        i_pin_source.lower(8'h04);
        grp(4'h1);
        check(request_fail, 1'b0);
    endtask

    // Simultaneous pulses, latching, lowest priority
    task automatic t_priority;
        wr(`SGS_CFG_OFS, 32'h7, `SGS_RESP_OKAY);
        grp(4'h1);
        check(init_seen, 8'hFE);
        i_pin_source.pulse(8'h28);
        grp(4'h4);
        check({last_evt.code, last_evt.on, last_evt.group},
              {EVT_ACTIVE, 1'b1, 4'h4});
        grp(4'h4);
        i_pin_source.pulse(8'h80);
        grp(4'h8);
    endtask

    // Static levels block lower groups; group eight blocks nothing
    task automatic t_level;
        i_pin_source.raise(8'h02);
        grp(4'h2);
        i_pin_source.pulse(8'h10);
        grp(4'h2);
        i_pin_source.pulse(8'h01);
        grp(4'h1);
        i_pin_source.lower(8'h02);
        i_pin_source.raise(8'h80);
        grp(4'h8);
        i_pin_source.pulse(8'h04);
        grp(4'h3);
        rd(`SGS_STA_OFS, 32'hFF3F, 32'h8003, `SGS_RESP_OKAY);
        i_pin_source.lower(8'h80);
    endtask

    // Operator override, remote commands, release
    task automatic t_override;
        wr(`SGS_REM_OFS, 32'h2, `SGS_RESP_OKAY);
        grp(4'h3);
        wr(`SGS_OVR_OFS, 32'h61, `SGS_RESP_OKAY);
        grp(4'h6);
        rd(`SGS_STA_OFS, 32'h3F, 32'h26, `SGS_RESP_OKAY);
        i_pin_source.pulse(8'h02);
        grp(4'h6);
        wr(`SGS_REM_OFS, 32'h3, `SGS_RESP_OKAY);
        grp(4'h3);
        wr(`SGS_OVR_OFS, 32'h0, `SGS_RESP_OKAY);
        grp(4'h3);
        wr(`SGS_OVR_OFS, 32'h1, `SGS_RESP_OKAY);
        i_pin_source.raise(8'h10);
        wr(`SGS_REM_OFS, 32'h7, `SGS_RESP_OKAY);
        grp(4'h3);
        wr(`SGS_OVR_OFS, 32'h0, `SGS_RESP_OKAY);
        grp(4'h5);
        i_pin_source.lower(8'h10);
    endtask

    // Fewer groups, rejected override, event mask, lane and bad addresses
    task automatic t_fail;
        wr(`SGS_CFG_OFS, 32'h3, `SGS_RESP_OKAY);
        grp(4'h1);
        wr(`SGS_OVR_OFS, 32'h11, `SGS_RESP_OKAY);
        grp(4'h1);
        check(request_fail, 1'b0);
        wr(`SGS_OVR_OFS, 32'h71, `SGS_RESP_OKAY);
        grp(4'h1);
        check(request_fail, 1'b1);
        wr(`SGS_OVR_OFS, 32'h21, `SGS_RESP_OKAY);
        grp(4'h2);
        check(request_fail, 1'b0);
        wr(`SGS_EVM_OFS, 32'h1, `SGS_RESP_OKAY);
        wr(`SGS_OVR_OFS, 32'h0, `SGS_RESP_OKAY);
        grp(4'h2);
        check({last_evt.code, last_evt.on}, {EVT_ACTIVE, 1'b1});
        wstrb <= 4'hE;
        wr(`SGS_CFG_OFS, 32'h7, `SGS_RESP_OKAY);
        wstrb <= 4'hF;
        rd(`SGS_CFG_OFS, 32'h7, 32'h3, `SGS_RESP_OKAY);
        wr(8'h18, 32'h0, `SGS_RESP_SLVERR);
        grp(4'h2);
    endtask

    // Main sequence
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hF;
        init_seen = 8'h00;
        last_evt = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(negedge aclk);
        t_reset();
        t_idle();
        t_priority();
        t_level();
        t_override();
        t_fail();
        conclude();
    end
endmodule // tb
